// *** rtl/encoding_match_decoder.sv ***
/*
   instruction classification: matches a fetched word against the pattern
   table, resolves overlaps, applies the condition check and the should-be
   check, and hands one class plus fields to the execute datapath.
   assumes fetch holds word and word_valid for the accepting edge and the
   datapath supplies the condition result for the same word.
*/
`include "encoding_match_defs.svh"
`default_nettype none

module encoding_match_decoder
(
   input  wire logic                         clock,
   input  wire logic                         rst,
   input  wire logic                         word_valid,
   input  wire logic [`WORD_WIDTH-1:0]       word,
   input  wire logic                         cond_check_pass,
   output logic                              out_valid,
   output encoding_match_pkg::decode_class_type out_class,
   output logic                              out_exec_enable,
   output logic [`IDX_WIDTH-1:0]             out_pattern,
   output logic [`FIELD_A_W-1:0]             out_field_a,
   output logic [`FIELD_B_W-1:0]             out_field_b
);

   pattern_results_if res ();                // per-pattern results

   pattern_bank u_bank
   (
      .word (word),
      .res  (res)
   );

   logic                                     any_match;     // some pattern matched
   logic                                     in_hint;       // word lies in hint space
   logic                                     needs_cond;    // matched patterns carry a check
   logic [`PAT_COUNT-1:0]                    remaining;     // matches left after discards
   logic                                     one_left;      // exactly one survivor
   logic [`IDX_WIDTH-1:0]                    sel;           // index of the survivor
   encoding_match_pkg::decode_class_type     next_class;    // class for this word
   logic [`FIELD_A_W-1:0]                    next_field_a;  // fields of the survivor
   logic [`FIELD_B_W-1:0]                    next_field_b;

   assign any_match  = |res.match;
   assign in_hint    = (word & `HINT_MASK) == `HINT_VAL;
   assign needs_cond = |(res.match & res.cond_use);
   assign remaining  = res.match & ~res.not_appl;
   assign one_left   = $onehot(remaining);

   // pick the survivor; with several left the table is broken anyway
   always_comb
   begin
      sel = '0;
      for (int i = 0; i < `PAT_COUNT; i++)
      begin
         if (remaining[i])
         begin
            sel = i[`IDX_WIDTH-1:0];
         end
      end
   end

   // classification in step order; earlier steps win
   always_comb
   begin
      next_field_a = res.field_a[sel*`FIELD_A_W +: `FIELD_A_W];
      next_field_b = res.field_b[sel*`FIELD_B_W +: `FIELD_B_W];
      if (!any_match)
      begin
         // unmatched words: hints idle, everything else traps
         next_class = in_hint ? encoding_match_pkg::no_operation
                              : encoding_match_pkg::reserved_trap_class;
      end
      else if (needs_cond && !cond_check_pass)
      begin
         next_class = encoding_match_pkg::no_operation;
      end
      else if (!one_left)
      begin
         // overlap the table failed to resolve; treat as impl_free_result_class
         next_class = encoding_match_pkg::impl_free_result_class;
      end
      else if (res.special[sel] || !res.consistent[sel])
      begin
         next_class = encoding_match_pkg::impl_free_result_class;
      end
      else if (res.sb_bad[sel])
      begin
         // checked only once fields exist, still before execution
         next_class = encoding_match_pkg::impl_free_result_class;
      end
      else
      begin
         next_class = encoding_match_pkg::class_valid;
      end
   end

   // one result per accepted word, one cycle wide
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         out_valid <= 1'b0;
      end
      else
      begin
         out_valid <= word_valid;
      end
   end

   // class and pattern index; held between words
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         out_class   <= encoding_match_pkg::no_operation;
         out_pattern <= '0;
      end
      else if (word_valid)
      begin
         out_class   <= next_class;
         out_pattern <= sel;
      end
   end

   // fields and execute enable: anything but a valid class is blanked so
   // no partial decode leaks into the datapath
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         out_exec_enable <= 1'b0;
         out_field_a     <= `RESET_FIELD_A;
         out_field_b     <= `RESET_FIELD_B;
      end
      else if (word_valid && next_class == encoding_match_pkg::class_valid)
      begin
         out_exec_enable <= 1'b1;
         out_field_a     <= next_field_a;
         out_field_b     <= next_field_b;
      end
      else
      begin
         out_exec_enable <= 1'b0;
         out_field_a     <= `RESET_FIELD_A;
         out_field_b     <= `RESET_FIELD_B;
      end
   end

   // checks

   // field a and field b sit side by side in the low twelve word bits
   logic [`FIELD_B_W+`FIELD_A_W-1:0]         word_fields;   // fields as fetched
   assign word_fields = word[`FIELD_B_W+`FIELD_B_LO-1:0];

   sequence s_nomatch;
      word_valid && !any_match;
   endsequence

   sequence s_cond_fail;
      word_valid && any_match && needs_cond && !cond_check_pass;
   endsequence

   sequence s_clean_single;
      word_valid && any_match && (!needs_cond || cond_check_pass) && one_left;
   endsequence

   chk_fixed_bits: assert property (@(posedge clock) disable iff (rst)
      ((word & 16'hF000) != 16'hD000) |-> !res.match[0])
      else $error("pattern 0 matched with a differing obligatory bit");

   chk_shouldbe_bad: assert property (@(posedge clock) disable iff (rst)
      s_clean_single ##0 (!res.special[sel] && res.consistent[sel] && res.sb_bad[sel])
      |=> out_valid && out_class == encoding_match_pkg::impl_free_result_class)
      else $error("should-be mismatch not classed impl_free_result_class");

   chk_nomatch_trap: assert property (@(posedge clock) disable iff (rst)
      s_nomatch ##0 !in_hint
      |=> out_valid && out_class == encoding_match_pkg::reserved_trap_class)
      else $error("unmatched word did not trap");

   chk_hint_idle: assert property (@(posedge clock) disable iff (rst)
      s_nomatch ##0 in_hint
      |=> out_class == encoding_match_pkg::no_operation && !out_exec_enable)
      else $error("unallocated hint not a no-operation");

   chk_cond_fail: assert property (@(posedge clock) disable iff (rst)
      s_cond_fail |=> out_class == encoding_match_pkg::no_operation && !out_exec_enable)
      else $error("failed condition check did not give no-operation");

   chk_cond_uniform: assert property (@(posedge clock) disable iff (rst)
      word_valid |-> ((res.match & res.cond_use) == '0) ||
                     ((res.match & res.cond_use) == res.match))
      else $error("condition check not uniform across matches");

   chk_field_load: assert property (@(posedge clock) disable iff (rst)
      out_exec_enable |-> {out_field_b, out_field_a} == $past(word_fields))
      else $error("executed fields differ from the accepted word");

   chk_dup_consist: assert property (@(posedge clock) disable iff (rst)
      s_clean_single ##0 (sel == 2'h2 && word[3:0] != word[7:4])
      |=> out_class == encoding_match_pkg::impl_free_result_class)
      else $error("inconsistent duplicated field not caught");

   chk_na_discard: assert property (@(posedge clock) disable iff (rst)
      word_valid && res.match[0] && res.match[1] && res.not_appl[0]
      |-> one_left && sel == 2'h1)
      else $error("not-applicable pattern kept");

   chk_special_case: assert property (@(posedge clock) disable iff (rst)
      s_clean_single ##0 res.special[sel]
      |=> !out_exec_enable && out_class == encoding_match_pkg::impl_free_result_class)
      else $error("special case still executed");

   chk_exec_valid: assert property (@(posedge clock) disable iff (rst)
      out_exec_enable |-> out_valid && out_class == encoding_match_pkg::class_valid)
      else $error("execution enabled for a non-valid class");

   chk_suppress: assert property (@(posedge clock) disable iff (rst)
      out_valid && out_class != encoding_match_pkg::class_valid
      |-> !out_exec_enable && out_field_a == `RESET_FIELD_A && out_field_b == `RESET_FIELD_B)
      else $error("terminated word leaked effects");

   chk_one_result: assert property (@(posedge clock) disable iff (rst)
      word_valid |=> out_valid ##1 (out_valid == $past(word_valid)))
      else $error("result not presented one cycle after accept");

endmodule

`default_nettype wire

// *** rtl/encoding_match_defs.svh ***
/*
   constants for the encoding match decoder: word width, pattern table,
   hint space and field positions.
   assumes every pattern is 16 bits wide and packed low pattern first.
*/
`ifndef ENCODING_MATCH_DEFS_SVH
`define ENCODING_MATCH_DEFS_SVH

`define WORD_WIDTH      16                      // instruction word width
`define PAT_COUNT       4                       // number of encoding patterns
`define IDX_WIDTH       2                       // width of a pattern index

// packed pattern table, pattern p at bits [16*p +: 16]
`define PAT_FIXED_MASK  64'hFFC0_FF00_FE00_F000 // obligatory bit positions
`define PAT_FIXED_VAL   64'hBA00_4600_DE00_D000 // obligatory bit values
`define PAT_SB_MASK     64'h0030_0000_0000_0000 // should-be bit positions
`define PAT_SB_VAL      64'h0000_0000_0000_0000 // should-be bit values
`define PAT_NA_MASK     64'h0000_0000_0000_0E00 // not-applicable test bits
`define PAT_NA_VAL      64'h0000_0000_0000_0E00 // not-applicable test value
`define PAT_COND_USE    4'h3                    // pattern starts with a condition check
`define PAT_DUP_CHECK   4'h4                    // pattern has a duplicated field a
`define PAT_SPECIAL_A   4'h4                    // field a all ones is a special case

// hint space: words here with no pattern are no-operations
`define HINT_MASK       16'hFF00
`define HINT_VAL        16'hBF00

// field positions
`define FIELD_A_LO      0                       // field a, 4 bits
`define FIELD_A_W       4
`define FIELD_A_DUP_LO  4                       // second copy of field a
`define FIELD_B_LO      4                       // field b, 8 bits
`define FIELD_B_W       8
`define FIELD_A_SPECIAL 4'hF                    // value that triggers the special case

`define RESET_FIELD_A   4'h0
`define RESET_FIELD_B   8'h00

`endif

// *** rtl/encoding_match_pkg.sv ***
/*
   types shared by the decoder modules.
   assumes nothing of its surroundings.
*/
`default_nettype none

package encoding_match_pkg;

   // one classification per accepted word
   typedef enum logic [1:0]
   {
      class_valid,
      no_operation,
      reserved_trap_class,
      impl_free_result_class
   } decode_class_type;

endpackage

`default_nettype wire

// *** rtl/pattern_bank.sv ***
/*
   compares one word against every encoding pattern in parallel and
   runs each pattern's field decoding independently.
   assumes the word is stable for the cycle; no state is held here.
*/
`include "encoding_match_defs.svh"
`default_nettype none

module pattern_bank
(
   input  wire logic [`WORD_WIDTH-1:0] word,
   pattern_results_if.bank             res
);

   localparam logic [`PAT_COUNT*`WORD_WIDTH-1:0] fixed_mask = `PAT_FIXED_MASK;
   localparam logic [`PAT_COUNT*`WORD_WIDTH-1:0] fixed_val  = `PAT_FIXED_VAL;
   localparam logic [`PAT_COUNT*`WORD_WIDTH-1:0] sb_mask    = `PAT_SB_MASK;
   localparam logic [`PAT_COUNT*`WORD_WIDTH-1:0] sb_val     = `PAT_SB_VAL;
   localparam logic [`PAT_COUNT*`WORD_WIDTH-1:0] na_mask    = `PAT_NA_MASK;
   localparam logic [`PAT_COUNT*`WORD_WIDTH-1:0] na_val     = `PAT_NA_VAL;
   localparam logic [`PAT_COUNT-1:0]             dup_check  = `PAT_DUP_CHECK;
   localparam logic [`PAT_COUNT-1:0]             special_a  = `PAT_SPECIAL_A;
   localparam logic [`PAT_COUNT-1:0]             cond_tab   = `PAT_COND_USE;

   logic [`FIELD_A_W-1:0] copy_a;      // field a as loaded from the word
   logic [`FIELD_A_W-1:0] copy_a_dup;  // second copy of field a

   assign copy_a     = word[`FIELD_A_LO +: `FIELD_A_W];
   assign copy_a_dup = word[`FIELD_A_DUP_LO +: `FIELD_A_W];

   // one slice per pattern; patterns never look at each other here
   genvar p;
   generate
      for (p = 0; p < `PAT_COUNT; p++)
      begin : g_pat
         // only obligatory bits decide a match
         assign res.match[p] = (word & fixed_mask[p*`WORD_WIDTH +: `WORD_WIDTH])
                               == fixed_val[p*`WORD_WIDTH +: `WORD_WIDTH];
         // should-be bits are noted, not used to reject
         assign res.sb_bad[p] = (word & sb_mask[p*`WORD_WIDTH +: `WORD_WIDTH])
                                != sb_val[p*`WORD_WIDTH +: `WORD_WIDTH];
         assign res.not_appl[p] = (na_mask[p*`WORD_WIDTH +: `WORD_WIDTH] != '0) &&
                                  ((word & na_mask[p*`WORD_WIDTH +: `WORD_WIDTH])
                                   == na_val[p*`WORD_WIDTH +: `WORD_WIDTH]);
         // duplicated field copies must agree where the pattern has them
         assign res.consistent[p] = !dup_check[p] || (copy_a == copy_a_dup);
         assign res.special[p]    = special_a[p] && (copy_a == `FIELD_A_SPECIAL);
         assign res.cond_use[p]   = cond_tab[p];
         // fields keep their own widths, loaded from their bit positions
         assign res.field_a[p*`FIELD_A_W +: `FIELD_A_W] = copy_a;
         assign res.field_b[p*`FIELD_B_W +: `FIELD_B_W] =
            word[`FIELD_B_LO +: `FIELD_B_W];
      end
   endgenerate

endmodule

`default_nettype wire

// *** rtl/pattern_results_if.sv ***
/*
   per-pattern results passed from the pattern bank to the resolver.
   assumes both ends sit on the same clock; the bank is purely combinational.
*/
`include "encoding_match_defs.svh"
`default_nettype none

interface pattern_results_if;
   logic [`PAT_COUNT-1:0]                match;       // obligatory bits agree
   logic [`PAT_COUNT-1:0]                not_appl;    // pattern says it does not apply
   logic [`PAT_COUNT-1:0]                sb_bad;      // a should-be bit differs
   logic [`PAT_COUNT-1:0]                consistent;  // duplicated fields agree
   logic [`PAT_COUNT-1:0]                special;     // field decode hit a special case
   logic [`PAT_COUNT-1:0]                cond_use;    // pattern carries a condition check
   logic [`PAT_COUNT*`FIELD_A_W-1:0]     field_a;     // field a per pattern
   logic [`PAT_COUNT*`FIELD_B_W-1:0]     field_b;     // field b per pattern

   modport bank
   (
      output match, not_appl, sb_bad, consistent, special, cond_use, field_a, field_b
   );
   modport resolver
   (
      input  match, not_appl, sb_bad, consistent, special, cond_use, field_a, field_b
   );
endinterface

`default_nettype wire

// *** test/fetch_stage_model.sv ***
/*
   fetch stage model: hands instruction words to the decoder at the falling edge.
   assumes the bench queues words through offer and the decoder samples at the rising edge.
*/
`include "encoding_match_defs.svh"
`default_nettype none

module fetch_stage_model
(
   input  wire logic                   clock,
   output logic                        word_valid,
   output logic [`WORD_WIDTH-1:0]      word,
   output logic                        cond_check_pass
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [`WORD_WIDTH-1:0] word_q[$];   // words still to hand over
   logic                   cond_q[$];   // condition result per word
   int                     gap_q[$];    // idle cycles before each word

   // lines start at zero; word_valid stays low until the first word
   initial
   begin
      word_valid = 1'b0;
      word = 16'h0000;
      cond_check_pass = 1'b0;
   end

   // queue one word, after gap idle cycles
   task automatic offer(input logic [`WORD_WIDTH-1:0] w, input logic c, input int gap);
      word_q.push_back(w);
      cond_q.push_back(c);
      gap_q.push_back(gap);
   endtask

   // one word a cycle; idle lines toggle so a stale value never looks valid
   always @(negedge clock)
   begin
      if ((word_q.size() > 0) && (gap_q[0] == 0))
      begin
         word_valid <= 1'b1;
         word <= word_q.pop_front();
         cond_check_pass <= cond_q.pop_front();
         void'(gap_q.pop_front());
      end
      else
      begin
         if (gap_q.size() > 0)
            gap_q[0] = gap_q[0] - 1;
         word_valid <= 1'b0;
         word <= ~word;
         cond_check_pass <= ~cond_check_pass;
      end
   end
endmodule

`default_nettype wire

// *** test/tb_encoding_match_decoder.sv ***
/*
   self-checking bench for the encoding match decoder.
   assumes the fetch model drives the word side and every answer lands one cycle later.
*/
`include "encoding_match_defs.svh"
`default_nettype none

module tb_encoding_match_decoder;
   timeunit 1ns;
   timeprecision 1ps;

   typedef encoding_match_pkg::decode_class_type cls_type;
   typedef struct
   {
      cls_type                cls;
      logic [`IDX_WIDTH-1:0]  pat;
      logic [`WORD_WIDTH-1:0] w;
   } expect_type;

   localparam cls_type c_ok   = encoding_match_pkg::class_valid;
   localparam cls_type c_idle = encoding_match_pkg::no_operation;
   localparam cls_type c_trap = encoding_match_pkg::reserved_trap_class;
   localparam cls_type c_free = encoding_match_pkg::impl_free_result_class;

   logic                    clock;           // 125 mhz
   logic                    rst;             // synchronous, active high
   wire logic               word_valid;      // from fetch model
   wire logic [15:0]        word;            // from fetch model
   wire logic               cond_check_pass; // from fetch model
   logic                    out_valid;       // answer strobe
   cls_type                 out_class;       // class of last word
   logic                    out_exec_enable; // execute go
   logic [`IDX_WIDTH-1:0]   out_pattern;     // surviving pattern
   logic [`FIELD_A_W-1:0]   out_field_a;     // field a
   logic [`FIELD_B_W-1:0]   out_field_b;     // field b
   int                      fails;           // mismatches seen
   int                      samples_checked; // comparisons made
   expect_type              exp_q[$];        // answers still owed
   expect_type              e;               // answer being judged
   logic                    taken_last;      // word accepted at last edge
   cls_type                 last_class;      // class that must hold

   fetch_stage_model u_fetch
   (
      .clock           (clock),
      .word_valid      (word_valid),
      .word            (word),
      .cond_check_pass (cond_check_pass)
   );

   encoding_match_decoder u_dut
   (
      .clock           (clock),
      .rst             (rst),
      .word_valid      (word_valid),
      .word            (word),
      .cond_check_pass (cond_check_pass),
      .out_valid       (out_valid),
      .out_class       (out_class),
      .out_exec_enable (out_exec_enable),
      .out_pattern     (out_pattern),
      .out_field_a     (out_field_a),
      .out_field_b     (out_field_b)
   );

   // free running clock
   initial
      clock = 1'b0;
   always #4 clock = ~clock;

   // single comparison point
   task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
      samples_checked++;
      if (seen !== want)
      begin
         fails++;
         $display("MISMATCH at %0t: %s seen %h want %h", $time, what, seen, want);
      end
   endtask

   // counts, verdict, end of run
   task automatic close_out();
      $display("checks %0d, mismatches %0d", samples_checked, fails);
      if ((fails == 0) && (samples_checked > 0))
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // queue a word and the answer it must earn
   task automatic send(input logic [15:0] w, input logic c, input int gap,
                       input cls_type cls, input logic [1:0] pat);
      expect_type x;
      x.cls = cls;
      x.pat = pat;
      x.w = w;
      exp_q.push_back(x);
      u_fetch.offer(w, c, gap);
   endtask

   // wait, bounded, until every owed answer was judged
   task automatic drain(input string name);
      int n;
      n = 0;
      while ((exp_q.size() != 0) && (n < 100))
      begin
         @(negedge clock);
         n++;
      end
      if (n >= 100)
      begin
         fails++;
         $display("MISMATCH at %0t: %s answers missing", $time, name);
      end
      repeat (2) @(negedge clock);
      $display("test %s done", name);
   endtask

   // accepted at this edge means answered at the next
   always @(posedge clock)
      taken_last <= !rst && word_valid;

   // judge outputs at the falling edge, where they are settled
   always @(negedge clock)
   begin
      if (rst === 1'b0)
      begin
         check(out_valid, taken_last, "answer timing");
         if (taken_last && (exp_q.size() > 0))
         begin
            e = exp_q.pop_front();
            last_class = e.cls;
            check(out_class, e.cls, "class");
            check(out_exec_enable, e.cls == c_ok, "exec enable");
            check(out_field_a, (e.cls == c_ok) ? e.w[3:0] : 4'h0, "field a");
            check(out_field_b, (e.cls == c_ok) ? e.w[11:4] : 8'h00, "field b");
            if (e.cls == c_ok)
               check(out_pattern, e.pat, "pattern");
         end
         else
         begin
            // no accept: strobes and fields quiet, class holds
            check(out_class, last_class, "class hold");
            check({out_exec_enable, out_field_a, out_field_b}, 16'h0000, "idle");
         end
      end
   end

   // reset, also in mid-run
   task automatic t_reset(input string name);
      @(negedge clock);
      rst = 1'b1;
      repeat (2) @(negedge clock);
      check({out_valid, out_exec_enable, out_pattern}, 16'h0000, "reset strobes");
      check(out_class, c_idle, "reset class");
      check({out_field_a, out_field_b}, 16'h0000, "reset fields");
      last_class = c_idle;
      rst = 1'b0;
      $display("test %s done", name);
   endtask

   // every pattern hit, back to back
   task automatic t_match();
      send(16'hD123, 1'b1, 0, c_ok, 2'h0);
      send(16'hDE45, 1'b1, 0, c_ok, 2'h1);
      send(16'h4677, 1'b1, 0, c_ok, 2'h2);
      send(16'hBA0F, 1'b1, 0, c_ok, 2'h3);
      drain("match");
   endtask

   // one obligatory bit off, hint space, slow fetch
   task automatic t_miss();
      send(16'hC123, 1'b1, 2, c_trap, 2'h0);
      send(16'h4700, 1'b1, 2, c_trap, 2'h0);
      send(16'hBF12, 1'b1, 2, c_idle, 2'h0);
      send(16'hBA4F, 1'b1, 2, c_trap, 2'h0);
      send(16'hBFFF, 1'b0, 2, c_idle, 2'h0);
      drain("miss");
   endtask

   // failed condition check, conditional and unconditional patterns
   task automatic t_cond();
      send(16'hD123, 1'b0, 0, c_idle, 2'h0);
      send(16'hDE45, 1'b0, 0, c_idle, 2'h0);
      send(16'h4677, 1'b0, 0, c_ok, 2'h2);
      drain("cond");
   endtask

   // special case, inconsistent copy, should-be bits
   task automatic t_special();
      send(16'h46FF, 1'b1, 1, c_free, 2'h2);
      send(16'h4613, 1'b1, 0, c_free, 2'h2);
      send(16'hBA1F, 1'b1, 1, c_free, 2'h3);
      send(16'hBA2F, 1'b1, 0, c_free, 2'h3);
      send(16'hBA3F, 1'b1, 0, c_free, 2'h3);
      drain("special");
   endtask

   // main sequence
   initial
   begin
      rst = 1'b1;
      fails = 0;
      samples_checked = 0;
      taken_last = 1'b0;
      last_class = c_idle;
      repeat (20) @(negedge clock);
      t_reset("reset");
      t_match();
      t_miss();
      t_cond();
      t_special();
      send(16'h4622, 1'b1, 0, c_ok, 2'h2);
      drain("valid before reset");
      t_reset("mid reset");
      t_match();
      close_out();
   end

   // hang guard, far beyond the under one hundred cycles the tests need
   initial
   begin
      repeat (5000) @(posedge clock);
      fails++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      close_out();
   end
endmodule

`default_nettype wire
